// [logic/lpp_regs.vh]
// Constants of the panel pixel path: modes, sizes, depths, dither period.
// Assumes one 40 MHz clock; included by the pixel pipeline, its checker and the bench.
// Notes on behaviour
// - Passive colour: 3375 colours, 256 per frame through the palette
// - Active colour: 16-bit pixels, 65536 colours
// - Passive monochrome: 15 gray levels per pixel
// - Line and line-count counters reach 1024
// - Pixels fetched into five-word input FIFO
// - Single panel one channel, dual both
// - 256-entry 12-bit palette indexed by pixels
// - 4-bit pixels use bottom 16 entries
// - Passive 12-bit pixels skip palette, dithered
// - Active 16-bit pixels skip palette and dither
// - Palette value dithered to 15 levels
// - Dither output through 19-entry pin FIFO
// - Data pins 4, 8 or 16 by type
// - Single mono: 4 or 8 pixels per clock
// - Single colour: eight pins, 2-2/3 pixels
// - Dual panel: two pin groups, doubled
// - TFT: line hsync, frame vsync, bias enable
// - TFT: palette entry straight to pins
// - Disabled: pins released to shared controller
// - Passive pixel clock only with data
// - Refill at four empty; underrun flag
// - Each word unpacked into configured pixels
`ifndef LPP_REGS_VH
`define LPP_REGS_VH
`define LPP_MODE_MONO   2'h0
`define LPP_MODE_PCOL   2'h1
`define LPP_MODE_TFT    2'h2
`define LPP_BPP_4       2'h0
`define LPP_BPP_8       2'h1
`define LPP_BPP_12      2'h2
`define LPP_BPP_16      2'h3
`define LPP_IN_DEPTH    5
`define LPP_IN_REFILL   1
`define LPP_BURST       3'h4
`define LPP_PIN_DEPTH   19
`define LPP_PAL_SIZE    256
`define LPP_DITH_PER    6'hE
`define LPP_LEVEL_MAX   4'hE
`define LPP_ENT_W       19
`endif

// [logic/lpp_pipeline.v]
// Pixel path of the panel controller: input FIFO, unpack, palette,
// dither, pin FIFO and panel timing. Configuration is held steady by
// the caller while enabled; the DMA answers dma_req with four words.
`timescale 1ns/100ps
`include "lpp_regs.vh"

module lpp_pipeline (
  // Clock and reset
  input  wire        clk,
  input  wire        srst,
  // Configuration
  input  wire        ctl_enable,
  input  wire [1:0]  cfg_mode,
  input  wire [1:0]  cfg_bpp,
  input  wire        cfg_dual,
  input  wire        cfg_mono8,
  input  wire [9:0]  cfg_ppl_m1,
  input  wire [9:0]  cfg_lpp_m1,
  input  wire [7:0]  cfg_pclk_div,
  input  wire [7:0]  cfg_line_wait,
  input  wire [7:0]  cfg_line_width,
  input  wire [7:0]  cfg_bias_lines,
  // Palette load
  input  wire        pal_we,
  input  wire [7:0]  pal_addr,
  input  wire [11:0] pal_data,
  // Frame buffer DMA
  output reg         dma_req,
  output reg         dma_chan,
  input  wire        dma_valid,
  input  wire [31:0] dma_data,
  output wire        dma_ready,
  // Status
  output reg         underrun_flag,
  output reg         underrun_irq,
  input  wire        underrun_clr,
  // Panel pins
  output reg  [15:0] panel_data_out,
  output reg         panel_pclk,
  output reg         panel_line_strobe,
  output reg         panel_frame_strobe,
  output reg         panel_bias,
  output reg         panel_pins_driven
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_DATA = 3'b010;
  localparam [2:0] ST_LINE = 3'b100;

  function [5:0] mod14;
    input [5:0] v;
    reg   [5:0] t;
    integer     i;
    begin
      t = v;
      for (i = 0; i < 3; i = i + 1)
        if (t >= `LPP_DITH_PER)
          t = t - `LPP_DITH_PER;
      mod14 = t;
    end
  endfunction

  // Level 15 is folded onto 14 so 15 steps span fully off to fully on
  function dith;
    input [3:0] lvl;
    input [5:0] thr;
    reg   [3:0] l;
    begin
      l = (lvl > `LPP_LEVEL_MAX) ? `LPP_LEVEL_MAX : lvl;
      dith = ({2'h0, l} > thr);
    end
  endfunction

  wire       run = ctl_enable & ~srst;
  wire       tft = (cfg_mode == `LPP_MODE_TFT);
  wire       dual = cfg_dual & ~tft;
  wire [4:0] hw = (cfg_mode == `LPP_MODE_MONO && !cfg_mono8) ? 5'h4 : 5'h8;

  // Input FIFO: shift-down, entry 0 is the bottom
  reg [32:0] in_mem [0:`LPP_IN_DEPTH-1];
  reg [2:0]  in_cnt_reg;
  reg [2:0]  burst_reg;
  reg        started_reg;
  wire       in_push = dma_valid & dma_ready;
  wire       in_pop;
  reg        in_pop_want;
  integer    k;

  assign dma_ready = run && (in_cnt_reg < `LPP_IN_DEPTH);

  always @(posedge clk)
  begin
    if (!run)
    begin
      in_cnt_reg    <= 3'h0;
      burst_reg     <= 3'h0;
      dma_req       <= 1'b0;
      dma_chan      <= 1'b0;
      started_reg   <= 1'b0;
      underrun_irq  <= 1'b0;
      if (srst)
        underrun_flag <= 1'b0;
      else if (underrun_clr)
        underrun_flag <= 1'b0;
      for (k = 0; k < `LPP_IN_DEPTH; k = k + 1)
        in_mem[k] <= 33'h0;
    end
    else
    begin
      // Top entry is only rewritten by a push, so the shift stops below it
      for (k = 0; k < `LPP_IN_DEPTH - 1; k = k + 1)
        if (in_pop)
          in_mem[k] <= in_mem[k+1];
      if (in_push)
        in_mem[in_cnt_reg - {2'h0, in_pop}] <= {dma_chan, dma_data};
      in_cnt_reg <= in_cnt_reg + {2'h0, in_push} - {2'h0, in_pop};
      if (in_push)
        started_reg <= 1'b1;
      // Refill once four of five entries are empty
      if (!dma_req && in_cnt_reg <= `LPP_IN_REFILL)
        dma_req <= 1'b1;
      else if (in_push && burst_reg == `LPP_BURST - 3'h1)
      begin
        dma_req  <= 1'b0;
        dma_chan <= dual ? ~dma_chan : 1'b0;
      end
      if (in_push)
        burst_reg <= (burst_reg == `LPP_BURST - 3'h1) ? 3'h0 : burst_reg + 3'h1;
      underrun_irq <= 1'b0;
      if (started_reg && in_cnt_reg == 3'h0 && in_pop_want)
      begin
        underrun_flag <= 1'b1;
        underrun_irq  <= 1'b1;
      end
      else if (underrun_clr)
        underrun_flag <= 1'b0;
    end
  end

  // Palette
  reg [11:0] pal_mem [0:`LPP_PAL_SIZE-1];
  always @(posedge clk)
  begin
    if (pal_we)
      pal_mem[pal_addr] <= pal_data;
  end

  // Unpacker
  reg [31:0] word_reg;
  reg        tag_reg;
  reg        word_vld_reg;
  reg [2:0]  sub_reg;
  reg [2:0]  last_sub;
  reg [15:0] raw;
  reg [11:0] pal_val;

  always @*
  begin
    in_pop_want = !word_vld_reg;
    case (cfg_bpp)
      `LPP_BPP_4:  last_sub = 3'h7;
      `LPP_BPP_8:  last_sub = 3'h3;
      default:     last_sub = 3'h1;
    endcase
    case (cfg_bpp)
      `LPP_BPP_4:  raw = {12'h0, word_reg[sub_reg*4 +: 4]};
      `LPP_BPP_8:  raw = {8'h0, word_reg[sub_reg*8 +: 8]};
      default:     raw = word_reg[sub_reg[0]*16 +: 16];
    endcase
    if (cfg_bpp == `LPP_BPP_4)
      pal_val = pal_mem[{4'h0, raw[3:0]}];
    else
      pal_val = pal_mem[raw[7:0]];
  end
  assign in_pop = in_pop_want && in_cnt_reg != 3'h0;

  // Packer: per half bit accumulators, eol pads the beat
  reg [11:0] acc_reg [0:1];
  reg [4:0]  cnt_reg [0:1];
  reg        eol_pend_reg;
  reg        sof_pend_reg;
  reg [9:0]  x_reg;
  reg [9:0]  y_reg;
  reg [5:0]  xph_reg;
  reg [5:0]  yph_reg;
  reg [5:0]  fph_reg;
  reg [`LPP_ENT_W-1:0] pin_mem [0:`LPP_PIN_DEPTH-1];
  reg [4:0]  wr_reg;
  reg [4:0]  rd_reg;
  reg [4:0]  pcnt_reg;

  wire       pin_full = (pcnt_reg == `LPP_PIN_DEPTH);
  wire       h = tag_reg & dual;
  wire [5:0] thr = mod14(fph_reg + xph_reg + yph_reg);
  reg  [2:0] pbits;
  reg  [4:0] pn;
  reg  [11:0] cval;

  always @*
  begin
    cval = (cfg_bpp == `LPP_BPP_12) ? raw[11:0] : pal_val;
    if (cfg_mode == `LPP_MODE_PCOL)
    begin
      pbits = {dith(cval[3:0], mod14(thr + 6'hA)),
               dith(cval[7:4], mod14(thr + 6'h5)),
               dith(cval[11:8], thr)};
      pn = 5'h3;
    end
    else
    begin
      pbits = {2'h0, dith(cval[3:0], thr)};
      pn = 5'h1;
    end
  end

  wire eol_ok = eol_pend_reg && cnt_reg[0] <= hw && (!dual || cnt_reg[1] <= hw);
  wire beat_ok = cnt_reg[0] >= hw && (!dual || cnt_reg[1] >= hw);
  wire tft_go = tft && word_vld_reg && !pin_full;
  wire pas_push = !tft && (eol_ok || beat_ok) && !pin_full;
  wire pas_go = !tft && word_vld_reg && !eol_pend_reg && cnt_reg[h] < hw;
  wire pix_go = tft_go || pas_go;
  wire last_x = (x_reg == cfg_ppl_m1) && !h;
  wire last_y = (y_reg == cfg_lpp_m1);
  wire [4:0] push_mask = hw - 5'h1;
  reg  [15:0] beat;

  always @*
  begin
    if (tft)
      beat = (cfg_bpp == `LPP_BPP_16) ? raw : {4'h0, pal_val};
    else if (dual)
      beat = (hw == 5'h4) ? {8'h0, acc_reg[1][3:0], acc_reg[0][3:0]}
                          : {acc_reg[1][7:0], acc_reg[0][7:0]};
    else
      beat = (hw == 5'h4) ? {12'h0, acc_reg[0][3:0]} : {8'h0, acc_reg[0][7:0]};
  end

  wire pin_push = tft_go || pas_push;
  wire beat_eol = tft ? last_x : eol_ok;
  wire beat_eof = beat_eol && last_y;
  wire pin_pop;

  always @(posedge clk)
  begin
    if (!run)
    begin
      word_vld_reg <= 1'b0;
      word_reg     <= 32'h0;
      tag_reg      <= 1'b0;
      sub_reg      <= 3'h0;
      acc_reg[0]   <= 12'h0;
      acc_reg[1]   <= 12'h0;
      cnt_reg[0]   <= 5'h0;
      cnt_reg[1]   <= 5'h0;
      eol_pend_reg <= 1'b0;
      sof_pend_reg <= 1'b1;
      x_reg        <= 10'h0;
      y_reg        <= 10'h0;
      xph_reg      <= 6'h0;
      yph_reg      <= 6'h0;
      fph_reg      <= 6'h0;
      wr_reg       <= 5'h0;
      rd_reg       <= 5'h0;
      pcnt_reg     <= 5'h0;
    end
    else
    begin
      if (in_pop)
      begin
        {tag_reg, word_reg} <= in_mem[0];
        word_vld_reg <= 1'b1;
        sub_reg      <= 3'h0;
      end
      else if (pix_go)
      begin
        sub_reg <= sub_reg + 3'h1;
        if (sub_reg == last_sub)
          word_vld_reg <= 1'b0;
      end
      if (pas_push)
      begin
        acc_reg[0] <= eol_ok ? 12'h0 : acc_reg[0] >> hw;
        acc_reg[1] <= eol_ok ? 12'h0 : acc_reg[1] >> hw;
        cnt_reg[0] <= eol_ok ? 5'h0 : cnt_reg[0] - hw;
        cnt_reg[1] <= (eol_ok || !dual) ? 5'h0 : cnt_reg[1] - hw;
        if (eol_ok)
          eol_pend_reg <= 1'b0;
      end
      else if (pas_go)
      begin
        acc_reg[h] <= acc_reg[h] | ({9'h0, pbits} << cnt_reg[h]);
        cnt_reg[h] <= cnt_reg[h] + pn;
        if (last_x)
          eol_pend_reg <= 1'b1;
      end
      if (pix_go && !h)
      begin
        x_reg   <= last_x ? 10'h0 : x_reg + 10'h1;
        xph_reg <= (last_x || xph_reg == `LPP_DITH_PER - 6'h1) ? 6'h0
                                                                : xph_reg + 6'h1;
        if (last_x)
        begin
          y_reg   <= last_y ? 10'h0 : y_reg + 10'h1;
          yph_reg <= (last_y || yph_reg == `LPP_DITH_PER - 6'h1) ? 6'h0
                                                                  : yph_reg + 6'h1;
          if (last_y)
            fph_reg <= mod14(fph_reg + 6'h1);
        end
      end
      if (pin_push)
      begin
        pin_mem[wr_reg] <= {beat_eof, sof_pend_reg, beat_eol, beat};
        wr_reg <= (wr_reg == `LPP_PIN_DEPTH - 1) ? 5'h0 : wr_reg + 5'h1;
        sof_pend_reg <= beat_eof;
      end
      if (pin_pop)
        rd_reg <= (rd_reg == `LPP_PIN_DEPTH - 1) ? 5'h0 : rd_reg + 5'h1;
      pcnt_reg <= pcnt_reg + {4'h0, pin_push} - {4'h0, pin_pop};
    end
  end

  // Panel timing: divider gives one tick per pixel clock half period
  reg [7:0] div_reg;
  reg       ph_reg;
  reg [2:0] st_reg;
  reg       shown_reg;
  reg       cur_eol_reg;
  reg       cur_eof_reg;
  reg [7:0] wcnt_reg;
  reg [7:0] bcnt_reg;
  wire      tick = (div_reg == cfg_pclk_div);
  wire      [`LPP_ENT_W-1:0] head = pin_mem[rd_reg];

  assign pin_pop = tick && !ph_reg && (st_reg == ST_DATA) && pcnt_reg != 5'h0;

  always @(posedge clk)
  begin
    if (!run)
    begin
      div_reg            <= 8'h0;
      ph_reg             <= 1'b0;
      st_reg             <= ST_IDLE;
      shown_reg          <= 1'b0;
      cur_eol_reg        <= 1'b0;
      cur_eof_reg        <= 1'b0;
      wcnt_reg           <= 8'h0;
      bcnt_reg           <= 8'h0;
      panel_data_out     <= 16'h0;
      panel_pclk         <= 1'b0;
      panel_line_strobe  <= 1'b0;
      panel_frame_strobe <= 1'b0;
      panel_bias         <= 1'b0;
      panel_pins_driven  <= 1'b0;
    end
    else
    begin
      panel_pins_driven <= 1'b1;
      div_reg <= tick ? 8'h0 : div_reg + 8'h1;
      if (tick)
      begin
        ph_reg <= ~ph_reg;
        panel_pclk <= tft ? ph_reg : (ph_reg & shown_reg);
        case (st_reg)
          ST_IDLE:
            st_reg <= ST_DATA;
          ST_DATA:
          begin
            if (!ph_reg)
            begin
              shown_reg <= pin_pop;
              if (pin_pop)
              begin
                panel_data_out <= head[15:0];
                cur_eol_reg    <= head[16];
                cur_eof_reg    <= head[18];
                if (head[17] && !tft)
                  panel_frame_strobe <= 1'b1;
              end
              if (tft)
                panel_bias <= pin_pop;
            end
            else if (shown_reg && cur_eol_reg)
            begin
              st_reg   <= ST_LINE;
              wcnt_reg <= cfg_line_wait + cfg_line_width;
            end
          end
          ST_LINE:
          begin
            shown_reg <= 1'b0;
            if (tft)
              panel_bias <= 1'b0;
            if (wcnt_reg == cfg_line_width)
            begin
              panel_line_strobe <= 1'b1;
              if (tft && cur_eof_reg)
                panel_frame_strobe <= 1'b1;
            end
            if (wcnt_reg == 8'h0)
            begin
              panel_line_strobe  <= 1'b0;
              panel_frame_strobe <= 1'b0;
              cur_eol_reg        <= 1'b0;
              st_reg             <= ST_DATA;
              if (!tft)
              begin
                bcnt_reg <= (bcnt_reg == cfg_bias_lines) ? 8'h0 : bcnt_reg + 8'h1;
                if (bcnt_reg == cfg_bias_lines)
                  panel_bias <= ~panel_bias;
              end
            end
            else
              wcnt_reg <= wcnt_reg - 8'h1;
          end
          default:
            st_reg <= ST_IDLE;
        endcase
      end
    end
  end

endmodule

// [verif/lpp_pipeline_asserts.sv]
// Port checker for the pixel pipeline.
// Bound to lpp_pipeline; one clock, synchronous reset.
`timescale 1ns/100ps
`include "lpp_regs.vh"
module lpp_pipeline_asserts (
  // Clock and reset
  input logic        clk,
  input logic        srst,
  // Configuration
  input logic        ctl_enable,
  input logic [1:0]  cfg_mode,
  input logic        cfg_dual,
  input logic        cfg_mono8,
  input logic [7:0]  cfg_pclk_div,
  // DMA
  input logic        dma_req,
  input logic        dma_chan,
  input logic        dma_valid,
  input logic        dma_ready,
  // Status
  input logic        underrun_flag,
  input logic        underrun_irq,
  // Panel
  input logic [15:0] panel_data_out,
  input logic        panel_pclk,
  input logic        panel_line_strobe,
  input logic        panel_frame_strobe,
  input logic        panel_bias,
  input logic        panel_pins_driven
);
  logic [2:0] burst_reg;
  logic [9:0] still_reg;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // Words taken under the open request
  always_ff @(posedge clk)
    if (srst || !ctl_enable || !dma_req)
      burst_reg <= 3'h0;
    else if (dma_valid && dma_ready)
      burst_reg <= burst_reg + 3'h1;
  // Cycles since the pixel clock last moved, saturating
  always_ff @(posedge clk)
    if (srst || !ctl_enable || panel_pclk != $past(panel_pclk))
      still_reg <= 10'h000;
    else if (still_reg != 10'h3FF)
      still_reg <= still_reg + 10'h001;
  AST_IDLE_OUTPUTS:
    assert property (!ctl_enable |=> !panel_pins_driven && !dma_req && panel_data_out == 16'h0000)
      else $error("outputs active while disabled");
  AST_PINS_DRIVEN:
    assert property (ctl_enable [*3] |-> panel_pins_driven)
      else $error("pins not driven while enabled");
  AST_IRQ_WITH_FLAG:
    assert property (underrun_irq |-> underrun_flag) else $error("irq without flag");
  AST_FLAG_RAISES_IRQ:
    assert property ($rose(underrun_flag) |-> underrun_irq) else $error("flag without irq");
  AST_REQ_STANDS:
    assert property (dma_req && !(dma_valid && dma_ready) ##1 ctl_enable |-> dma_req)
      else $error("request dropped early");
  AST_BURST_FOUR:
    assert property ($fell(dma_req) && ctl_enable |-> burst_reg == 3'h4)
      else $error("burst not four words");
  AST_TFT_PCLK_FREE:
    assert property (ctl_enable && cfg_mode == `LPP_MODE_TFT
      |-> still_reg <= {1'b0, cfg_pclk_div, 1'b0} + 10'h003) else $error("pixel clock stopped");
  AST_PASSIVE_STILL_LINE:
    assert property (cfg_mode != `LPP_MODE_TFT && panel_line_strobe && $past(panel_line_strobe)
      |-> $stable(panel_pclk)) else $error("pixel clock moved in line strobe");
  AST_ONE_CHANNEL:
    assert property (!cfg_dual |-> !dma_chan) else $error("second channel in single panel");
  AST_TFT_VSYNC_IN_HSYNC:
    assert property (cfg_mode == `LPP_MODE_TFT && panel_frame_strobe |-> panel_line_strobe)
      else $error("vertical sync outside horizontal sync");
  AST_TFT_OE_LOW_IN_HSYNC:
    assert property (cfg_mode == `LPP_MODE_TFT && panel_line_strobe |-> !panel_bias)
      else $error("output enable high during horizontal sync");
  AST_MONO4_HIGH_PINS_IDLE:
    assert property (ctl_enable && cfg_mode == `LPP_MODE_MONO && !cfg_mono8 && !cfg_dual
      |-> panel_data_out[15:4] == 12'h000) else $error("upper pins used in four pin mode");
endmodule

bind lpp_pipeline lpp_pipeline_asserts u_chk (
  .clk, .srst, .ctl_enable, .cfg_mode, .cfg_dual, .cfg_mono8, .cfg_pclk_div, .dma_req,
  .dma_chan, .dma_valid, .dma_ready, .underrun_flag, .underrun_irq, .panel_data_out,
  .panel_pclk, .panel_line_strobe, .panel_frame_strobe, .panel_bias, .panel_pins_driven
);

// [verif/lpp_panel_model.sv]
// Panel model: in TFT mode only, latches a beat on each pixel clock rise with enable.
// Sampled by the system clock; pixel clock is much slower.
`timescale 1ns/100ps
module lpp_panel_model (
  // Clock and mode
  input  logic        clk,
  input  logic        tft,
  // Panel pins
  input  logic [15:0] panel_data_out,
  input  logic        panel_pclk,
  input  logic        panel_bias,
  input  logic        panel_line_strobe,
  // Observations
  output logic        beat_stb,
  output logic [15:0] beat_data,
  output int          line_cnt
);
  logic pclk_d = 1'b0;
  logic line_d = 1'b0;
  initial beat_stb = 1'b0;
  initial line_cnt = 0;
  always @(posedge clk)
  begin
    pclk_d <= panel_pclk;
    line_d <= panel_line_strobe;
    beat_stb <= tft && panel_bias && panel_pclk && !pclk_d;
    beat_data <= panel_data_out;
    if (panel_line_strobe && !line_d)
      line_cnt <= line_cnt + 1;
  end
endmodule

// [verif/lpp_pipeline_tb_top.sv]
// Bench: DMA source, palette load, TFT data checks, underrun.
// Assumes the panel model and the bound checker.
`timescale 1ns/100ps
`include "lpp_regs.vh"
module lpp_pipeline_tb_top;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        ctl_enable = 1'b0;
  logic [1:0]  cfg_mode = 2'h2;
  logic [1:0]  cfg_bpp = 2'h3;
  logic        cfg_dual = 1'b0;
  logic        cfg_mono8 = 1'b0;
  logic [7:0]  cfg_bias_lines = 8'h00;
  logic        pal_we = 1'b0;
  logic [7:0]  pal_addr = 8'h00;
  logic [11:0] pal_data = 12'h000;
  logic        dma_valid = 1'b0;
  logic [31:0] dma_data = 32'h0000_0000;
  logic        underrun_clr = 1'b0;
  logic        feed = 1'b0;
  logic        dma_req, dma_chan, dma_ready, underrun_flag, underrun_irq, beat_stb;
  logic        panel_pclk, panel_line_strobe, panel_frame_strobe, panel_bias, panel_pins_driven;
  logic [15:0] panel_data_out, beat_data;
  logic [15:0] lfsr = 16'hC5AF;
  logic [11:0] pal [256];
  logic [15:0] exp_q [$];
  logic [1:0]  modes [5] = '{2'h2, 2'h2, 2'h2, 2'h0, 2'h1};
  logic [1:0]  bpps [5] = '{2'h3, 2'h1, 2'h0, 2'h0, 2'h2};
  int          bad_count = 0;
  int          tests_run = 0;
  int          left = 0;
  int          beats = 0;
  int          line_cnt;

  always #12.5 clk = ~clk;

  lpp_pipeline u_dut (
    .clk(clk), .srst(srst), .ctl_enable(ctl_enable), .cfg_mode(cfg_mode), .cfg_bpp(cfg_bpp),
    .cfg_dual(cfg_dual), .cfg_mono8(cfg_mono8), .cfg_ppl_m1(10'h007), .cfg_lpp_m1(10'h003),
    .cfg_pclk_div(8'h03), .cfg_line_wait(8'h02), .cfg_line_width(8'h01),
    .cfg_bias_lines(cfg_bias_lines), .pal_we(pal_we), .pal_addr(pal_addr), .pal_data(pal_data),
    .dma_req(dma_req), .dma_chan(dma_chan), .dma_valid(dma_valid), .dma_data(dma_data),
    .dma_ready(dma_ready), .underrun_flag(underrun_flag), .underrun_irq(underrun_irq),
    .underrun_clr(underrun_clr), .panel_data_out(panel_data_out), .panel_pclk(panel_pclk),
    .panel_line_strobe(panel_line_strobe), .panel_frame_strobe(panel_frame_strobe),
    .panel_bias(panel_bias), .panel_pins_driven(panel_pins_driven)
  );

  lpp_panel_model u_panel (
    .clk(clk), .tft(cfg_mode == `LPP_MODE_TFT), .panel_data_out(panel_data_out),
    .panel_pclk(panel_pclk), .panel_bias(panel_bias), .panel_line_strobe(panel_line_strobe),
    .beat_stb(beat_stb), .beat_data(beat_data), .line_cnt(line_cnt)
  );

  function automatic logic [15:0] step(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic conclude;
    $display("comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Palette beats carry zeros above bit 11, so all 16 pins are compared
  task automatic check_beat(input logic [15:0] got, input logic [15:0] exp);
    check_val(got, exp);
  endtask

  // Low bits first; one pixel per TFT beat
  task automatic note(input logic [31:0] w);
    for (int k = 0; k < 8; k++)
      case (cfg_bpp)
        `LPP_BPP_16: if (k < 2) exp_q.push_back(w[16*k +: 16]);
        `LPP_BPP_8: if (k < 4) exp_q.push_back({4'h0, pal[w[8*k +: 8]]});
        default: exp_q.push_back({4'h0, pal[{4'h0, w[4*k +: 4]}]});
      endcase
  endtask

  task automatic wait_for(ref int v, input int n);
    for (int k = 0; k < 20000 && v < n; k++)
      @(posedge clk);
    if (v < n)
    begin
      bad_count++;
      conclude();
    end
  endtask

  task automatic run(input logic [1:0] m, input logic [1:0] b);
    int l0;
    @(posedge clk);
    ctl_enable <= 1'b0;
    repeat (4) @(posedge clk);
    exp_q.delete();
    beats = 0;
    l0 = line_cnt;
    cfg_mode <= m;
    cfg_bpp <= b;
    // Dual request is set in TFT, where the block must ignore it
    cfg_dual <= (m == `LPP_MODE_TFT);
    cfg_mono8 <= lfsr[0];
    cfg_bias_lines <= {7'h00, lfsr[1]};
    feed <= 1'b1;
    ctl_enable <= 1'b1;
    wait_for(line_cnt, l0 + 6);
    if (m == `LPP_MODE_TFT)
      wait_for(beats, 40);
  endtask

  // DMA source: holds each word until taken, four per request
  always @(posedge clk)
    if (srst || !ctl_enable)
    begin
      left = 0;
      dma_valid <= 1'b0;
      dma_data <= ~dma_data;
    end
    else
    begin
      if (dma_valid && dma_ready)
      begin
        if (cfg_mode == `LPP_MODE_TFT)
          note(dma_data);
        left--;
      end
      else if (left == 0 && dma_req && feed && !dma_valid)
        left = 4;
      if (!dma_valid || dma_ready)
      begin
        lfsr = step(lfsr);
        dma_valid <= left > 0;
        dma_data <= left > 0 ? {lfsr, step(lfsr)} : ~dma_data;
      end
    end

  always @(posedge clk)
    if (beat_stb === 1'b1)
    begin
      beats++;
      check_beat(beat_data, exp_q.size() ? exp_q.pop_front() : 'x);
    end

  initial
  begin
    repeat (100000) @(posedge clk);
    bad_count++;
    conclude();
  end

  initial
  begin
    repeat (16) @(posedge clk);
    srst <= 1'b0;
    // Equal components keep the check blind to colour order on the pins
    for (int k = 0; k < 256; k++)
    begin
      @(posedge clk);
      lfsr = step(lfsr);
      pal[k] = {3{lfsr[3:0]}};
      pal_we <= 1'b1;
      pal_addr <= k[7:0];
      pal_data <= {3{lfsr[3:0]}};
    end
    @(posedge clk);
    pal_we <= 1'b0;
    for (int k = 0; k < 5; k++)
      run(modes[k], bpps[k]);
    run(`LPP_MODE_TFT, `LPP_BPP_16);
    underrun_clr <= 1'b1;
    @(posedge clk);
    underrun_clr <= 1'b0;
    repeat (2) @(posedge clk);
    check_val(underrun_flag, 1'b0);
    feed <= 1'b0;
    for (int k = 0; k < 2000 && underrun_flag !== 1'b1; k++)
      @(posedge clk);
    check_val(underrun_flag, 1'b1);
    ctl_enable <= 1'b0;
    repeat (3) @(posedge clk);
    check_val(underrun_flag, 1'b1);
    underrun_clr <= 1'b1;
    @(posedge clk);
    underrun_clr <= 1'b0;
    repeat (2) @(posedge clk);
    check_val(underrun_flag, 1'b0);
    conclude();
  end
endmodule
